// ===== src/slr_pins.sv
`timescale 1ns/100ps
// Operation
// R1 - Low strap of lines 0-3: low drives them as outputs, high makes them inputs.
// R2 - High strap of lines 4-7: low drives them as outputs, high makes them inputs.
// R3 - Each status line is either a closure input or an application output.
// R4 - Transmit amplifier enable is high exactly while transmitting.
// R5 - Acknowledge output goes high when an acknowledgement follows a sent control message.
// R6 - Latch high toggles outputs per command; low keeps them active only while received.
// R7 - Acknowledgement is requested only after a valid control message with enable high.
// R8 - Receive amplifier enable is high exactly while receiving; the code holds it low while transmit is also active.
// R9 - Transmit and receive amplifier enables are never high together.
module slr_pins
  import slr_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  input wire logic low_group_direction_strap_i,
  input wire logic high_group_direction_strap_i,
  input wire logic latch_select_i,
  input wire logic ack_enable_i,
  input wire logic [7:0] status_lines_in_i,
  output logic [7:0] status_lines_out_o,
  output logic [7:0] status_lines_oe_o,
  output logic [7:0] closures_o,
  input wire slr_cmd_s cmd_i,
  input wire slr_radio_s radio_i,
  output logic tx_amplifier_enable_o,
  output logic rx_amplifier_enable_o,
  output logic ack_received_o,
  output logic ack_send_req_o
);
  logic rst_s1_r;
  logic rst_n_r;
  logic [2:0] strap_lo_sync_r;
  logic [2:0] strap_hi_sync_r;
  logic [2:0] latch_sync_r;
  logic [2:0] acken_sync_r;
  logic [7:0] line_s1_r;
  logic [7:0] line_s2_r;
  logic [7:0] line_s3_r;
  logic strap_lo_r;
  logic strap_hi_r;
  logic latch_r;
  logic acken_r;
  logic [7:0] out_r;
  logic [7:0] out_nxt;
  logic [7:0] input_mask;
  logic ack_wait_r;
  slr_radio_e radio_r;

  // Filtered level: changes only once second and third stages agree
  function automatic logic filt(input logic s2, input logic s3, input logic cur);
    return (s2 == s3) ? s3 : cur;
  endfunction

  // Reset release through two flops
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_s1_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n_r <= rst_s1_r;
    end
  end

  // Three-flop synchronisers for pins
  always_ff @(posedge clk_sys_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      strap_lo_sync_r <= {3{SLR_STRAP_RST}};
      strap_hi_sync_r <= {3{SLR_STRAP_RST}};
      latch_sync_r <= 3'h0;
      acken_sync_r <= 3'h0;
      line_s1_r <= 8'h00;
      line_s2_r <= 8'h00;
      line_s3_r <= 8'h00;
    end else if (ce_i) begin
      strap_lo_sync_r <= {strap_lo_sync_r[1:0], low_group_direction_strap_i};
      strap_hi_sync_r <= {strap_hi_sync_r[1:0], high_group_direction_strap_i};
      latch_sync_r <= {latch_sync_r[1:0], latch_select_i};
      acken_sync_r <= {acken_sync_r[1:0], ack_enable_i};
      line_s1_r <= status_lines_in_i;
      line_s2_r <= line_s1_r;
      line_s3_r <= line_s2_r;
    end
  end

  // Filtered control levels; straps default to input (safe, nothing driven)
  always_ff @(posedge clk_sys_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      strap_lo_r <= SLR_STRAP_RST;
      strap_hi_r <= SLR_STRAP_RST;
      latch_r <= 1'b0;
      acken_r <= 1'b0;
    end else if (ce_i) begin
      strap_lo_r <= filt(strap_lo_sync_r[1], strap_lo_sync_r[2], strap_lo_r); // see R1
      strap_hi_r <= filt(strap_hi_sync_r[1], strap_hi_sync_r[2], strap_hi_r); // see R2
      latch_r <= filt(latch_sync_r[1], latch_sync_r[2], latch_r);
      acken_r <= filt(acken_sync_r[1], acken_sync_r[2], acken_r);
    end
  end

  // Lines of a high-strapped group are inputs
  assign input_mask = {{SLR_GROUP_W{strap_hi_r}}, {SLR_GROUP_W{strap_lo_r}}}; // see R1 see R2

  // Closure capture on input lines, filtered per bit
  always_ff @(posedge clk_sys_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      closures_o <= 8'h00;
    end else if (ce_i) begin
      for (int i = 0; i < SLR_LINES; i++) begin
        closures_o[i] <= input_mask[i] & filt(line_s2_r[i], line_s3_r[i], closures_o[i]); // see R3
      end
    end
  end

  // Output state: toggle when latched, follow command when momentary
  always_comb begin
    out_nxt = out_r;
    if (latch_r) begin
      if (cmd_i.valid) begin
        out_nxt = out_r ^ cmd_i.lines; // see R6
      end
    end else begin
      out_nxt = cmd_i.valid ? cmd_i.lines : 8'h00; // see R6
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      out_r <= SLR_OUT_RST;
    end else if (ce_i) begin
      out_r <= out_nxt;
    end
  end

  // Pin drive: only output-group lines are enabled
  always_ff @(posedge clk_sys_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      status_lines_out_o <= 8'h00;
      status_lines_oe_o <= 8'h00;
    end else if (ce_i) begin
      status_lines_out_o <= out_nxt & ~input_mask; // see R3
      status_lines_oe_o <= ~input_mask; // see R1 see R2
    end
  end

  // Radio activity; transmit wins so both amplifiers never overlap
  always_ff @(posedge clk_sys_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      radio_r <= SLR_IDLE;
    end else if (ce_i) begin
      case ({radio_i.tx_active, radio_i.rx_active})
        2'b10, 2'b11: radio_r <= SLR_TX; // see R9
        2'b01: radio_r <= SLR_RX;
        default: radio_r <= SLR_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      tx_amplifier_enable_o <= 1'b0;
      rx_amplifier_enable_o <= 1'b0;
    end else if (ce_i) begin
      tx_amplifier_enable_o <= (radio_r == SLR_TX); // see R4
      rx_amplifier_enable_o <= (radio_r == SLR_RX); // see R8
    end
  end

  // Acknowledgement tracking; a new control send re-arms and clears the flag
  always_ff @(posedge clk_sys_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      ack_wait_r <= 1'b0;
      ack_received_o <= 1'b0;
    end else if (ce_i) begin
      if (radio_i.ctrl_sent) begin
        ack_wait_r <= 1'b1;
        ack_received_o <= 1'b0;
      end else if (radio_i.ack_rcvd && ack_wait_r) begin
        ack_wait_r <= 1'b0;
        ack_received_o <= 1'b1; // see R5
      end
    end
  end

  // One-cycle request to the radio core to send an acknowledgement
  always_ff @(posedge clk_sys_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      ack_send_req_o <= 1'b0;
    end else if (ce_i) begin
      ack_send_req_o <= radio_i.ctrl_rcvd & acken_r; // see R7
    end
  end

  property p_no_overlap;
    @(posedge clk_sys_i) disable iff (!rst_n_r)
    !(tx_amplifier_enable_o && rx_amplifier_enable_o);
  endproperty
  a_no_overlap: assert property (p_no_overlap) else $error("amplifier enables overlap"); // see R9

  property p_tx_follow;
    @(posedge clk_sys_i) disable iff (!rst_n_r)
    (ce_i && radio_i.tx_active) ##1 ce_i |=> tx_amplifier_enable_o;
  endproperty
  a_tx_follow: assert property (p_tx_follow) else $error("tx enable late"); // see R4

  property p_rx_follow;
    @(posedge clk_sys_i) disable iff (!rst_n_r)
    (ce_i && radio_i.rx_active && !radio_i.tx_active) ##1 ce_i |=> rx_amplifier_enable_o;
  endproperty
  a_rx_follow: assert property (p_rx_follow) else $error("rx enable late"); // see R8

  property p_lo_inputs_undriven;
    @(posedge clk_sys_i) disable iff (!rst_n_r)
    strap_lo_r && $past(strap_lo_r) && $past(ce_i) |-> status_lines_oe_o[3:0] == 4'h0;
  endproperty
  a_lo_inputs_undriven: assert property (p_lo_inputs_undriven) else $error("low group driven"); // see R1

  property p_hi_outputs_driven;
    @(posedge clk_sys_i) disable iff (!rst_n_r)
    !strap_hi_r && $past(!strap_hi_r) && $past(ce_i) |-> status_lines_oe_o[7:4] == 4'hf;
  endproperty
  a_hi_outputs_driven: assert property (p_hi_outputs_driven) else $error("high group not driven"); // see R2

  property p_closure_masked;
    @(posedge clk_sys_i) disable iff (!rst_n_r)
    (closures_o & status_lines_oe_o) == 8'h00 || !$past(ce_i);
  endproperty
  a_closure_masked: assert property (p_closure_masked) else $error("closure on output line"); // see R3

  property p_toggle;
    @(posedge clk_sys_i) disable iff (!rst_n_r)
    ce_i && latch_r && cmd_i.valid |=> out_r == ($past(out_r) ^ $past(cmd_i.lines));
  endproperty
  a_toggle: assert property (p_toggle) else $error("latched toggle wrong"); // see R6

  property p_ack_send;
    @(posedge clk_sys_i) disable iff (!rst_n_r)
    ce_i |=> ack_send_req_o == ($past(radio_i.ctrl_rcvd) && $past(acken_r));
  endproperty
  a_ack_send: assert property (p_ack_send) else $error("ack request wrong"); // see R7

  property p_ack_rcvd;
    @(posedge clk_sys_i) disable iff (!rst_n_r)
    ce_i && ack_wait_r && radio_i.ack_rcvd && !radio_i.ctrl_sent |=> ack_received_o;
  endproperty
  a_ack_rcvd: assert property (p_ack_rcvd) else $error("ack not flagged"); // see R5
endmodule

// ===== include/slr_pkg.sv
package slr_pkg;
  // Line group geometry
  localparam int SLR_GROUP_W = 4;
  localparam int SLR_LINES = 8;
  localparam int SLR_LO_BASE = 0;
  localparam int SLR_HI_BASE = 4;
  // Reset values
  localparam logic [7:0] SLR_OUT_RST = 8'h00;
  localparam logic SLR_STRAP_RST = 1'b1;

  // Radio core activity states
  typedef enum logic [1:0] {
    SLR_IDLE = 2'b00,
    SLR_TX = 2'b01,
    SLR_RX = 2'b10
  } slr_radio_e;

  // Command from the radio core towards the status outputs
  typedef struct packed {
    logic valid;
    logic [7:0] lines;
  } slr_cmd_s;

  // Radio core events seen by the pin logic
  typedef struct packed {
    logic tx_active;
    logic rx_active;
    logic ctrl_sent;
    logic ack_rcvd;
    logic ctrl_rcvd;
  } slr_radio_s;
endpackage

// ===== test/slr_app_model.sv
`timescale 1ns/100ps
module slr_app_model
  import slr_pkg::*;
(
  input wire logic [7:0] status_lines_out_i,
  input wire logic [7:0] status_lines_oe_i,
  input wire logic [7:0] buttons_i,
  output logic [7:0] status_lines_in_o
);
  // Driven lines follow the device; the rest show closed buttons, else the pull-down low
  assign status_lines_in_o = (status_lines_oe_i & status_lines_out_i) | (~status_lines_oe_i & buttons_i);
endmodule

// ===== test/slr_pins_tb_top.sv
`timescale 1ns/100ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin failures++; \
  $display("Error at %0t: got %h expected %h", $time, (a), (b)); end end
module slr_pins_tb_top
  import slr_pkg::*;
;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic lo_strap = 1'b1;
  logic hi_strap = 1'b1;
  logic latch = 1'b0;
  logic ack_en = 1'b0;
  logic ce = 1'b1;
  logic [7:0] buttons = 8'h00;
  logic [7:0] lines_in;
  logic [7:0] out;
  logic [7:0] oe;
  logic [7:0] clos;
  slr_cmd_s cmd = '0;
  slr_radio_s radio = '0;
  logic tx_amp;
  logic rx_amp;
  logic ack_rx;
  logic ack_req;
  int failures = 0;
  int checked = 0;

  // System clock, 8 ns period
  always #4 clk = ~clk;

  slr_pins dut (.clk_sys_i(clk), .rstn_i(rstn), .ce_i(ce), .low_group_direction_strap_i(lo_strap),
    .high_group_direction_strap_i(hi_strap), .latch_select_i(latch), .ack_enable_i(ack_en),
    .status_lines_in_i(lines_in), .status_lines_out_o(out), .status_lines_oe_o(oe), .closures_o(clos),
    .cmd_i(cmd), .radio_i(radio), .tx_amplifier_enable_o(tx_amp), .rx_amplifier_enable_o(rx_amp),
    .ack_received_o(ack_rx), .ack_send_req_o(ack_req));

  slr_app_model app (.status_lines_out_i(out), .status_lines_oe_i(oe), .buttons_i(buttons),
    .status_lines_in_o(lines_in));

  // Inputs change only at falling edges
  task cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  task final_report;
    $display("Checks %0d, mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Cut a hang short well beyond the expected run
  initial begin
    #8000;
    failures++;
    $display("Error at %0t: timeout", $time);
    final_report;
  end

  // Straps stay fixed between tests, long enough to clear the synchronisers
  initial begin
    cyc(12);
    rstn = 1'b1;
    cyc(8);
    `CHK(oe, 8'h00)
    lo_strap = 1'b0;
    cyc(8);
    `CHK(oe, 8'h0f)
    lo_strap = 1'b1;
    hi_strap = 1'b0;
    buttons = 8'hff;
    cyc(8);
    `CHK(oe, 8'hf0)
    // Released lines reach the closure filter only after the enables drop
    cyc(4);
    `CHK(clos, 8'h0f)
    $display("Test directions done");
    latch = 1'b1;
    cyc(8);
    cmd = '{1'b1, 8'h11};
    cyc(1);
    `CHK(out, 8'h10)
    cyc(1);
    cmd.valid = 1'b0;
    `CHK(out, 8'h00)
    latch = 1'b0;
    cyc(8);
    cmd = '{1'b1, 8'h30};
    cyc(2);
    `CHK(out, 8'h30)
    cmd.valid = 1'b0;
    cyc(1);
    `CHK(out, 8'h00)
    // Clock enable low freezes the outputs despite a command
    ce = 1'b0;
    cmd.valid = 1'b1;
    cyc(2);
    `CHK(out, 8'h00)
    ce = 1'b1;
    cyc(1);
    `CHK(out, 8'h30)
    cmd.valid = 1'b0;
    cyc(1);
    `CHK(out, 8'h00)
    $display("Test outputs done");
    radio.tx_active = 1'b1;
    cyc(2);
    `CHK({tx_amp, rx_amp}, 2'b10)
    radio.rx_active = 1'b1;
    cyc(2);
    `CHK({tx_amp, rx_amp}, 2'b10)
    radio.tx_active = 1'b0;
    cyc(2);
    `CHK({tx_amp, rx_amp}, 2'b01)
    radio.rx_active = 1'b0;
    cyc(2);
    `CHK({tx_amp, rx_amp}, 2'b00)
    $display("Test amplifiers done");
    radio.ack_rcvd = 1'b1;
    cyc(1);
    radio.ack_rcvd = 1'b0;
    `CHK(ack_rx, 1'b0)
    radio.ctrl_sent = 1'b1;
    cyc(1);
    radio.ctrl_sent = 1'b0;
    cyc(1);
    radio.ack_rcvd = 1'b1;
    cyc(1);
    radio.ack_rcvd = 1'b0;
    `CHK(ack_rx, 1'b1)
    radio.ctrl_sent = 1'b1;
    cyc(1);
    radio.ctrl_sent = 1'b0;
    `CHK(ack_rx, 1'b0)
    $display("Test acknowledge done");
    ack_en = 1'b1;
    cyc(8);
    radio.ctrl_rcvd = 1'b1;
    cyc(1);
    radio.ctrl_rcvd = 1'b0;
    `CHK(ack_req, 1'b1)
    cyc(1);
    `CHK(ack_req, 1'b0)
    ack_en = 1'b0;
    cyc(8);
    radio.ctrl_rcvd = 1'b1;
    cyc(1);
    radio.ctrl_rcvd = 1'b0;
    `CHK(ack_req, 1'b0)
    $display("Test ack request done");
    final_report;
  end
endmodule
